/* File: hw/ihm_pkg.sv */
// Constants, command codes and state types shared by the instrument bus message handler.
// Assumes a single 200 MHz clock and bus lines that are active low on the pins.
`default_nettype none

package ihm_pkg;

  // Clock rate and data settle time before the data-valid strobe
  localparam int CLK_MHZ        = 200;
  localparam int SETTLE_NS      = 2000;
  localparam int SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;  // Least time, rounded up
  localparam int SETTLE_W       = 9;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC - 1);

  // Width of the synchronised pin bundle and its bit positions
  localparam int SYNC_W   = 14;
  localparam int POS_DIO  = 0;   // Bits 7..0 data lines
  localparam int POS_ATN  = 8;
  localparam int POS_REN  = 9;
  localparam int POS_IFC  = 10;
  localparam int POS_DAV  = 11;
  localparam int POS_NRFD = 12;
  localparam int POS_NDAC = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 14'h0000;  // All lines false

  // Universal and addressed command bytes, seven bits
  localparam logic [6:0] CMD_GTL = 7'h01;  // Go to local
  localparam logic [6:0] CMD_SDC = 7'h04;  // Selected clear
  localparam logic [6:0] CMD_GET = 7'h08;  // Group trigger
  localparam logic [6:0] CMD_LLO = 7'h11;  // Local lockout
  localparam logic [6:0] CMD_DCL = 7'h14;  // Clear all
  localparam logic [6:0] CMD_SPE = 7'h18;  // Serial poll enable
  localparam logic [6:0] CMD_SPD = 7'h19;  // Serial poll disable

  // Address groups in bits 6..5 and the "none" address
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [4:0] ADDR_NONE  = 5'h1F;

  // Status byte bit that reports a pending service request
  localparam int STB_RQS = 6;

  // Handshake states
  typedef enum logic [0:0] {AH_READY, AH_HOLD} ihm_ah_t;
  typedef enum logic [2:0] {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_VALID, SH_DONE} ihm_sh_t;

endpackage

`default_nettype wire

/* File: hw/ihm_sync_if.sv */
// Carrier for synchronised bus lines between the pin synchroniser and the handler core.
// Assumes both ends run on the same clock; lines are true-high here.
`default_nettype none

interface ihm_sync_if;
  logic [ihm_pkg::SYNC_W-1:0] lines;  // Filtered, true-high bus lines

  modport sync (output lines);
  modport core (input  lines);
endinterface

`default_nettype wire

/* File: hw/ihm_pin_sync.sv */
// Three-stage synchroniser for every incoming bus line, one generate loop over the bundle.
// Assumes the pins are asynchronous; a change is taken once stages two and three agree.
`default_nettype none

module ihm_pin_sync (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [ihm_pkg::SYNC_W-1:0] pinTrue,
  ihm_sync_if.sync                        syncBus
);
  import ihm_pkg::*;

  logic [SYNC_W-1:0] st1_q, st2_q, st3_q;  // Three sampling stages
  logic [SYNC_W-1:0] out_q, out_d;         // Accepted level

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      // Take a new level only when the later two stages agree
      always_comb begin
        out_d[i] = (st2_q[i] == st3_q[i]) ? st3_q[i] : out_q[i];
      end
    end
  endgenerate

  // Stage registers; first stage only feeds the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st1_q <= SYNC_RST;
      st2_q <= SYNC_RST;
      st3_q <= SYNC_RST;
      out_q <= SYNC_RST;
    end else begin
      st1_q <= pinTrue;
      st2_q <= st1_q;
      st3_q <= st2_q;
      out_q <= out_d;
    end
  end

  assign syncBus.lines = out_q;
endmodule

`default_nettype wire

/* File: hw/ihm_core.sv */
// Instrument-side message handler for a parallel instrument bus: addressing, trigger,
// clear, remote/local, lockout, service request and serial poll status byte.
// Assumes active-low open-drain bus pins resolved outside; every oe is high while driving low.
//
// Summary of operation
// RULE1: Controller addresses parties before data moves.
// RULE2: Addressed trigger starts predefined triggered function.
// RULE3: Controller holds remote enable before trigger.
// RULE4: Selected or universal clear performs device clear.
// RULE5: Remote enable plus listen address enters remote.
// RULE6: Go-to-local returns only listening instruments.
// RULE7: Lockout blocks front-panel return to local.
// RULE8: Controller holds remote enable before lockout.
// RULE9: Remote enable false clears lockout, goes local.
// RULE10: Service request held until polled or gone.
// RULE11: Serial poll returns eight-bit status byte.
// RULE12: Polled instrument sends byte, releases request.
// RULE13: Controller ends poll with poll disable.
// RULE14: No parallel poll response, configuration ignored.
// RULE15: Controller picks poll level and line.
// RULE16: Controller passes control by talk, take-control.
// RULE17: System controller may abort at any time.
// RULE18: Status byte bit six marks request service.
`default_nettype none

module ihm_core (
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bus pins, active low
  input  wire logic [7:0] dioIn_n,
  output var  logic [7:0] dioOut_n,
  output var  logic       dioOe,
  input  wire logic       atnIn_n,
  input  wire logic       renIn_n,
  input  wire logic       ifcIn_n,
  input  wire logic       davIn_n,
  output var  logic       davOut_n,
  output var  logic       davOe,
  input  wire logic       nrfdIn_n,
  output var  logic       nrfdOut_n,
  output var  logic       nrfdOe,
  input  wire logic       ndacIn_n,
  output var  logic       ndacOut_n,
  output var  logic       ndacOe,
  output var  logic       srqOut_n,
  output var  logic       srqOe,
  // Instrument side
  input  wire logic [4:0] myAddr,
  input  wire logic       serviceNeeded,
  input  wire logic [5:0] statusCause,
  input  wire logic       panelLocal,
  output var  logic       triggerPulse,
  output var  logic       clearPulse,
  output var  logic       dataStrobe,
  output var  logic [7:0] dataByte,
  output var  logic       remoteMode,
  output var  logic       lockoutMode,
  output var  logic       listenMode,
  output var  logic       talkMode
);
  import ihm_pkg::*;

  ihm_sync_if syncBus ();  // Synchronised lines

  // Pins into true-high form before the synchroniser
  ihm_pin_sync u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pinTrue ({~ndacIn_n, ~nrfdIn_n, ~davIn_n, ~ifcIn_n, ~renIn_n, ~atnIn_n, ~dioIn_n}),
    .syncBus (syncBus)
  );

  logic [7:0] busData;  // Received byte, true-high
  logic       atn, ren, ifc, dav, nrfd, ndac;
  assign busData = syncBus.lines[POS_DIO +: 8];
  assign atn     = syncBus.lines[POS_ATN];
  assign ren     = syncBus.lines[POS_REN];
  assign ifc     = syncBus.lines[POS_IFC];
  assign dav     = syncBus.lines[POS_DAV];
  assign nrfd    = syncBus.lines[POS_NRFD];
  assign ndac    = syncBus.lines[POS_NDAC];

  // Acceptor handshake and device state
  ihm_ah_t    ah_q, ah_d;             // Acceptor state
  logic       lstn_q, lstn_d;         // Addressed to listen
  logic       tlk_q, tlk_d;           // Addressed to talk
  logic       rem_q, rem_d;           // Remote operating condition
  logic       llo_q, llo_d;           // Local lockout
  logic       spe_q, spe_d;           // Serial poll mode
  logic       trg_q, trg_d;           // Trigger pulse
  logic       clr_q, clr_d;           // Clear pulse
  logic       dstb_q, dstb_d;         // Data byte pulse
  logic [7:0] dbyte_q, dbyte_d;       // Last data byte
  logic       nrfdDrv_q, nrfdDrv_d;   // Holding not-ready low
  logic       ndacDrv_q, ndacDrv_d;   // Holding not-accepted low
  logic       take;                   // A byte is being accepted now
  logic [6:0] cmd;                    // Command byte, parity bit dropped

  // Source handshake and service request state
  ihm_sh_t             sh_q, sh_d;          // Source state
  logic [SETTLE_W-1:0] settle_q, settle_d;  // Settle countdown
  logic [7:0]          stb_q, stb_d;        // Status byte on the lines
  logic                dioOe_q, dioOe_d;    // Driving data lines
  logic                davDrv_q, davDrv_d;  // Holding data valid low
  logic                svcPrev_q;           // Last service input
  logic                srq_q, srq_d;        // Request pending
  logic                stbSent;             // Status byte accepted by controller

  assign cmd  = busData[6:0];
  // Accept in command mode always, in data mode only as listener
  assign take = (ah_q == AH_READY) && dav && (atn || lstn_q);

  // Acceptor next state and message decode
  always_comb begin
    ah_d      = ah_q;
    lstn_d    = lstn_q;
    tlk_d     = tlk_q;
    rem_d     = rem_q;
    llo_d     = llo_q;
    spe_d     = spe_q;
    trg_d     = 1'b0;
    clr_d     = 1'b0;
    dstb_d    = 1'b0;
    dbyte_d   = dbyte_q;
    nrfdDrv_d = 1'b0;
    ndacDrv_d = 1'b0;
    if (atn || lstn_q) begin
      // Ready: not-accepted held low; hold: not-ready held low
      ndacDrv_d = (ah_d == AH_READY);
    end
    case (ah_q)
      AH_READY: begin
        if (take) begin
          ah_d = AH_HOLD;
        end
      end
      AH_HOLD: begin
        if (!dav) begin
          ah_d = AH_READY;
        end
      end
      default: ah_d = AH_READY;
    endcase
    if (atn || lstn_q) begin
      nrfdDrv_d = (ah_d == AH_HOLD);
      ndacDrv_d = (ah_d == AH_READY);
    end
    if (take && atn) begin
      // RULE1: addressing in command mode
      if (cmd[6:5] == GRP_LISTEN) begin
        if (cmd[4:0] == ADDR_NONE) begin
          lstn_d = 1'b0;
        end else if (cmd[4:0] == myAddr) begin
          lstn_d = 1'b1;
          // RULE5: remote on listen address
          if (ren) begin
            rem_d = 1'b1;
          end
        end
      end else if (cmd[6:5] == GRP_TALK) begin
        // Any other talk address untalks us
        tlk_d = (cmd[4:0] == myAddr);
        if (tlk_d) begin
          lstn_d = 1'b0;
        end
      end else if (cmd == CMD_GET && lstn_q) begin
        // RULE2: trigger addressed listeners
        trg_d = 1'b1;
      end else if (cmd == CMD_DCL || (cmd == CMD_SDC && lstn_q)) begin
        // RULE4: universal or selected clear
        clr_d = 1'b1;
      end else if (cmd == CMD_GTL && lstn_q) begin
        // RULE6: only listeners return local
        rem_d = 1'b0;
      end else if (cmd == CMD_LLO && ren) begin
        // RULE7: enter lockout
        llo_d = 1'b1;
      end else if (cmd == CMD_SPE) begin
        spe_d = 1'b1;
      end else if (cmd == CMD_SPD) begin
        spe_d = 1'b0;
      end
      // RULE14: configuration and secondaries fall through unused
    end else if (take) begin
      // Data byte to the instrument
      dstb_d  = 1'b1;
      dbyte_d = busData;
    end
    // RULE7: panel local only without lockout
    if (panelLocal && !llo_q) begin
      rem_d = 1'b0;
    end
    // RULE9: remote enable false drops remote and lockout
    if (!ren) begin
      rem_d = 1'b0;
      llo_d = 1'b0;
    end
    // Interface clear unaddresses and ends a poll
    if (ifc) begin
      lstn_d = 1'b0;
      tlk_d  = 1'b0;
      spe_d  = 1'b0;
    end
  end

  // Acceptor and device state registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ah_q      <= AH_READY;
      lstn_q    <= 1'b0;
      tlk_q     <= 1'b0;
      rem_q     <= 1'b0;
      llo_q     <= 1'b0;
      spe_q     <= 1'b0;
      trg_q     <= 1'b0;
      clr_q     <= 1'b0;
      dstb_q    <= 1'b0;
      dbyte_q   <= 8'h00;
      nrfdDrv_q <= 1'b0;
      ndacDrv_q <= 1'b0;
    end else begin
      ah_q      <= ah_d;
      lstn_q    <= lstn_d;
      tlk_q     <= tlk_d;
      rem_q     <= rem_d;
      llo_q     <= llo_d;
      spe_q     <= spe_d;
      trg_q     <= trg_d;
      clr_q     <= clr_d;
      dstb_q    <= dstb_d;
      dbyte_q   <= dbyte_d;
      nrfdDrv_q <= nrfdDrv_d;
      ndacDrv_q <= ndacDrv_d;
    end
  end

  assign stbSent = (sh_q == SH_VALID) && !ndac;

  // Source handshake for the status byte and service request
  always_comb begin
    sh_d     = sh_q;
    settle_d = settle_q;
    stb_d    = stb_q;
    dioOe_d  = 1'b0;
    davDrv_d = 1'b0;
    srq_d    = srq_q;
    case (sh_q)
      SH_IDLE: begin
        if (tlk_q && spe_q && !atn) begin
          // RULE11: latch eight-bit status byte
          // RULE18: bit six reports pending request
          stb_d          = {1'b0, srq_q, statusCause};
          settle_d       = SETTLE_LOAD;
          sh_d           = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        if (settle_q == '0) begin
          sh_d = SH_WAIT_RFD;
        end else begin
          settle_d = settle_q - 1'b1;
        end
      end
      SH_WAIT_RFD: begin
        if (!nrfd) begin
          sh_d = SH_VALID;
        end
      end
      SH_VALID: begin
        // RULE12: byte taken once not-accepted releases
        if (!ndac) begin
          sh_d = SH_DONE;
        end
      end
      SH_DONE: begin
        // One byte per poll address
        if (!tlk_q || !spe_q) begin
          sh_d = SH_IDLE;
        end
      end
      default: sh_d = SH_IDLE;
    endcase
    // Command mode takes the lines back from the talker
    if (atn && sh_d != SH_DONE) begin
      sh_d = SH_IDLE;
    end
    dioOe_d  = (sh_d == SH_SETTLE) || (sh_d == SH_WAIT_RFD) || (sh_d == SH_VALID);
    davDrv_d = (sh_d == SH_VALID);
    // RULE10: hold request until polled or cause gone
    if (stbSent || !serviceNeeded) begin
      srq_d = 1'b0;
    end
    // A new request wins over a same-cycle release
    if (serviceNeeded && !svcPrev_q) begin
      srq_d = 1'b1;
    end
  end

  // Source and service request registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sh_q      <= SH_IDLE;
      settle_q  <= '0;
      stb_q     <= 8'h00;
      dioOe_q   <= 1'b0;
      davDrv_q  <= 1'b0;
      svcPrev_q <= 1'b0;
      srq_q     <= 1'b0;
    end else begin
      sh_q      <= sh_d;
      settle_q  <= settle_d;
      stb_q     <= stb_d;
      dioOe_q   <= dioOe_d;
      davDrv_q  <= davDrv_d;
      svcPrev_q <= serviceNeeded;
      srq_q     <= srq_d;
    end
  end

  // Pin drive straight from flip-flops; released lines read high
  assign dioOut_n     = ~stb_q;
  assign dioOe        = dioOe_q;
  assign davOut_n     = ~davDrv_q;
  assign davOe        = davDrv_q;
  assign nrfdOut_n    = ~nrfdDrv_q;
  assign nrfdOe       = nrfdDrv_q;
  assign ndacOut_n    = ~ndacDrv_q;
  assign ndacOe       = ndacDrv_q;
  assign srqOut_n     = ~srq_q;
  assign srqOe        = srq_q;
  assign triggerPulse = trg_q;
  assign clearPulse   = clr_q;
  assign dataStrobe   = dstb_q;
  assign dataByte     = dbyte_q;
  assign remoteMode   = rem_q;
  assign lockoutMode  = llo_q;
  assign listenMode   = lstn_q;
  assign talkMode     = tlk_q;
endmodule

`default_nettype wire

/* File: tb/ihm_core_assertions.sv */
// Concurrent checks on the handler's pins and instrument-side outputs.
// Assumes one clock and the core's synchronous active-low reset.
`default_nettype none
module ihm_core_assertions (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       renIn_n,
  input wire logic       serviceNeeded,
  input wire logic [5:0] statusCause,
  input wire logic       panelLocal,
  input wire logic       triggerPulse,
  input wire logic       clearPulse,
  input wire logic [7:0] dioOut_n,
  input wire logic       dioOe,
  input wire logic       srqOe,
  input wire logic       remoteMode,
  input wire logic       lockoutMode,
  input wire logic       listenMode,
  input wire logic       talkMode
);
  timeunit 1ns;
  timeprecision 100ps;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  trig_listen_a: assert property (triggerPulse |-> $past(listenMode))
    else $error("trigger pulse while not listening");
  remote_ren_a: assert property ($rose(remoteMode) |-> !$past(renIn_n, 5))
    else $error("remote entered without remote enable");
  // Eight cycles covers sync delay plus one edge
  ren_local_a: assert property (renIn_n [*8] |-> !remoteMode && !lockoutMode)
    else $error("remote or lockout kept after enable dropped");
  lock_panel_a: assert property ((!renIn_n) [*6] ##0 (lockoutMode && remoteMode && panelLocal && !listenMode)
    |=> remoteMode)
    else $error("panel took back control during lockout");
  srq_rise_a: assert property ($rose(serviceNeeded) |=> srqOe)
    else $error("service request not raised");
  srq_hold_a: assert property (srqOe && serviceNeeded && !dioOe |=> srqOe)
    else $error("service request dropped early");
  srq_drop_a: assert property (!serviceNeeded |=> !srqOe)
    else $error("service request kept with no cause");
  stb_byte_a: assert property ($rose(dioOe) |-> dioOut_n[7] && dioOut_n[5:0] == ~$past(statusCause))
    else $error("status byte content wrong");
  stb_rqs_a: assert property ($rose(dioOe) |-> dioOut_n[6] == !$past(srqOe))
    else $error("request bit wrong in status byte");
  pp_silent_a: assert property (dioOe |-> talkMode)
    else $error("data lines driven while not talker");

  // Main scenarios reached
  cover property (triggerPulse);
  cover property (clearPulse);
  cover property ($fell(dioOe) && !srqOe);
endmodule

bind ihm_core ihm_core_assertions u_chk (.clock, .rst_n, .renIn_n, .serviceNeeded, .statusCause, .panelLocal,
  .triggerPulse, .clearPulse, .dioOut_n, .dioOe, .srqOe, .remoteMode, .lockoutMode, .listenMode, .talkMode);
`default_nettype wire

/* File: tb/ihm_ctl_model.sv */
// Behavioural bus controller: attention, remote enable, clear and handshake lines.
// Assumes the bench resolves each open-drain line; a released line reads high.
`default_nettype none
module ihm_ctl_model (
  input  wire logic       clock,
  input  wire logic [7:0] dioBus_n,
  input  wire logic       davBus_n,
  input  wire logic       nrfdBus_n,
  input  wire logic       ndacBus_n,
  output var  logic [7:0] dioDrv_n,
  output var  logic       atnDrv_n,
  output var  logic       renDrv_n,
  output var  logic       ifcDrv_n,
  output var  logic       davDrv_n,
  output var  logic       nrfdDrv_n,
  output var  logic       ndacDrv_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // All lines released at start
  initial begin
    {dioDrv_n, atnDrv_n, renDrv_n, ifcDrv_n, davDrv_n, nrfdDrv_n, ndacDrv_n} = 14'h3FFF;
  end

  // Changes land just after the edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  // bytes sent in command or data mode
  task automatic send(input logic [7:0] b, input logic cmd = 1'h1);
    atnDrv_n = ~cmd;
    dioDrv_n = ~b;
    // Wait for a ready acceptor
    for (int n = 0; n < 99 && !(nrfdBus_n && !ndacBus_n); n++) tick();
    davDrv_n = 1'h0;
    // Valid stands at least one edge, even with no acceptor
    tick();
    for (int n = 0; n < 99 && !ndacBus_n; n++) tick();
    davDrv_n = 1'h1;
    // Released lines float up
    dioDrv_n = 8'hFF;
    for (int n = 0; n < 99 && ndacBus_n; n++) tick();
  endtask

  // one status byte taken as listener
  task automatic readStb(output logic [7:0] b);
    atnDrv_n = 1'h1;
    ndacDrv_n = 1'h0;
    for (int n = 0; n < 999 && davBus_n; n++) tick();
    b = ~dioBus_n;
    nrfdDrv_n = 1'h0;
    ndacDrv_n = 1'h1;
    for (int n = 0; n < 99 && !davBus_n; n++) tick();
    nrfdDrv_n = 1'h1;
  endtask

  task automatic abort();
    ifcDrv_n = 1'h0;
    repeat (8) tick();
    ifcDrv_n = 1'h1;
  endtask

  task automatic remote(input logic on);
    renDrv_n = ~on;
    repeat (8) tick();
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the handler core against a behavioural controller.
// Assumes four clocks of pin latency and a long settle before a status byte.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ihm_pkg::*;

  localparam logic [4:0] MY_ADDR = 5'h0B;
  localparam logic [7:0] MLA     = {1'h0, GRP_LISTEN, MY_ADDR};
  localparam logic [7:0] MTA     = {1'h0, GRP_TALK, MY_ADDR};
  logic       clock = 1'h0;
  logic       rst_n = 1'h0;
  logic       serviceNeeded = 1'h0;
  logic       panelLocal = 1'h0;
  logic [5:0] statusCause = 6'h00;
  logic [4:0] myAddr = MY_ADDR;  // Own address, moved late in the run
  logic [7:0] dioDrv_n, dioOut_n, dataByte, stb;
  logic       atnDrv_n, renDrv_n, ifcDrv_n, davDrv_n, nrfdDrv_n, ndacDrv_n, dataStrobe;
  logic       dioOe, davOut_n, davOe, nrfdOut_n, nrfdOe, ndacOut_n, ndacOe, srqOut_n, srqOe;
  logic       triggerPulse, clearPulse, remoteMode, lockoutMode, listenMode, talkMode;
  int         bad_count = 0, n_tests = 0, trigCount = 0, clearCount = 0, dataCount = 0, cyc = 0;

  // Open-drain lines read low if any party pulls
  wire [7:0] dioBus_n  = dioDrv_n & (dioOut_n | ~{8{dioOe}});
  wire       davBus_n  = davDrv_n & (davOut_n | ~davOe);
  wire       nrfdBus_n = nrfdDrv_n & (nrfdOut_n | ~nrfdOe);
  wire       ndacBus_n = ndacDrv_n & (ndacOut_n | ~ndacOe);

  `define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

  ihm_core dut (.clock, .rst_n, .dioIn_n(dioBus_n), .dioOut_n, .dioOe, .atnIn_n(atnDrv_n), .renIn_n(renDrv_n),
    .ifcIn_n(ifcDrv_n), .davIn_n(davBus_n), .davOut_n, .davOe, .nrfdIn_n(nrfdBus_n), .nrfdOut_n, .nrfdOe,
    .ndacIn_n(ndacBus_n), .ndacOut_n, .ndacOe, .srqOut_n, .srqOe, .myAddr, .serviceNeeded,
    .statusCause, .panelLocal, .triggerPulse, .clearPulse, .dataStrobe, .dataByte, .remoteMode,
    .lockoutMode, .listenMode, .talkMode);
  ihm_ctl_model ctl (.clock, .dioBus_n, .davBus_n, .nrfdBus_n, .ndacBus_n, .dioDrv_n, .atnDrv_n,
    .renDrv_n, .ifcDrv_n, .davDrv_n, .nrfdDrv_n, .ndacDrv_n);

  always #2.5 clock = ~clock;

  // Pulse tallies; ceiling cuts a hang short
  always @(posedge clock) begin
    if (triggerPulse === 1'h1) trigCount++;
    if (clearPulse === 1'h1) clearCount++;
    if (dataStrobe === 1'h1) dataCount++;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Listen address without, then with, remote enable
  task automatic t_remote();
    int d0;
    d0 = dataCount;
    ctl.send(MLA);
    `CHK("listen", {listenMode, remoteMode}, 2'h2)
    ctl.remote(1'h1);
    ctl.send(MLA);
    `CHK("remote", remoteMode, 1'h1)
    // One data byte once addressed as listener
    ctl.send(8'hA5, 1'h0);
    `CHK("data count", dataCount, d0 + 1)
    `CHK("data byte", dataByte, 8'hA5)
    $display("test remote done");
  endtask

  // Trigger and clears as listener, then as talker
  task automatic t_trig();
    int t0;
    int c0;
    int d0;
    t0 = trigCount;
    c0 = clearCount;
    for (int k = 0; k < 2; k++) begin
      ctl.send({1'h0, CMD_GET});
      ctl.send({1'h0, CMD_SDC});
      ctl.send({1'h0, CMD_DCL});
      ctl.send(MTA);
    end
    // Data byte refused once only talker
    d0 = dataCount;
    ctl.send(8'h3C, 1'h0);
    `CHK("no data", dataCount, d0)
    `CHK("kept byte", dataByte, 8'hA5)
    `CHK("trig", trigCount, t0 + 1)
    `CHK("clear", clearCount, c0 + 3)
    $display("test trigger done");
  endtask

  // Local only moves listeners; lockout; enable drop; abort
  task automatic t_lock();
    ctl.send({1'h0, CMD_GTL});
    `CHK("unaddressed", remoteMode, 1'h1)
    ctl.send(MLA);
    ctl.send({1'h0, CMD_GTL});
    `CHK("gtl", remoteMode, 1'h0)
    ctl.send(MLA);
    ctl.send({1'h0, CMD_LLO});
    ctl.send(MTA);
    panelLocal = 1'h1;
    repeat (8) ctl.tick();
    `CHK("locked", {remoteMode, lockoutMode}, 2'h3)
    panelLocal = 1'h0;
    ctl.remote(1'h0);
    `CHK("freed", {remoteMode, lockoutMode}, 2'h0)
    ctl.abort();
    `CHK("abort", {talkMode, listenMode}, 2'h0)
    ctl.remote(1'h1);
    $display("test lockout done");
  endtask

  // Request, two polls, withdrawal
  task automatic t_poll();
    statusCause = 6'h2A;
    serviceNeeded = 1'h1;
    repeat (3) ctl.tick();
    `CHK("srq", {srqOe, srqOut_n}, 2'h2)
    ctl.send({1'h0, CMD_SPE});
    ctl.send(MTA);
    ctl.readStb(stb);
    `CHK("stb rqs", stb, 8'h6A)
    `CHK("srq off", srqOe, 1'h0)
    ctl.send({1'h0, CMD_SPD});
    statusCause = 6'h15;
    ctl.send({1'h0, CMD_SPE});
    ctl.readStb(stb);
    `CHK("stb idle", stb, 8'h15)
    ctl.send({1'h0, CMD_SPD});
    serviceNeeded = 1'h0;
    ctl.tick();
    serviceNeeded = 1'h1;
    repeat (3) ctl.tick();
    serviceNeeded = 1'h0;
    repeat (3) ctl.tick();
    `CHK("srq gone", srqOe, 1'h0)
    $display("test poll done");
  endtask

  // Parallel poll setup ignored; control passed on
  task automatic t_pp();
    // low level then high level codes
    ctl.send(8'h05);
    ctl.send(8'h60);
    ctl.send(8'h6F);
    `CHK("no ppr", dioOe, 1'h0)
    ctl.send({1'h0, GRP_TALK, 5'h03});
    ctl.send(8'h09);
    `CHK("passed", talkMode, 1'h0)
    // Decode follows a moved own address
    myAddr = 5'h03;
    ctl.send({1'h0, GRP_TALK, 5'h03});
    `CHK("new addr", talkMode, 1'h1)
    $display("test pass control done");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'h1;
    repeat (6) ctl.tick();
    `CHK("idle", {remoteMode, lockoutMode, listenMode, talkMode, srqOe, dioOe}, 6'h00)
    t_remote();
    t_trig();
    t_lock();
    t_poll();
    t_pp();
    stop_test();
  end
endmodule
`default_nettype wire
